// ==== hw/scg_map.vh ====
// Constants for the sleep-mode unit clock gating register block
// What this block does
// - Bit 26 gates comparator c clock in sleep, resets 0, set means clocked
// - Bits 24 and 25 gate comparators a and b likewise, reset 0
// - Bits 31 to 27 are reserved, read zero, writes ignored
// - Access to an unclocked unit is answered with a bus fault
// - Sleep gating applies only with auto gating select set, else run gating
// - Every gate bit resets to 0 so all units start disabled
`ifndef SCG_MAP_VH
`define SCG_MAP_VH
`define SCG_AW 12
`define SCG_OFF_SLEEP_GATE 12'h114
`define SCG_OFF_RUN_GATE 12'h104
`define SCG_OFF_CTRL 12'h060
`define SCG_OFF_IRQ_STAT 12'h200
`define SCG_OFF_IRQ_MASK 12'h204
`define SCG_OFF_FAULT_UNIT 12'h208
`define SCG_RW_MASK 32'h0707_1013
`define SCG_GATE_RESET 32'h0000_0000
`define SCG_CTRL_AUTO_BIT 27
`define SCG_NUNITS 11
`define SCG_UNIT_W 4
`define SCG_IRQ_W 2
`define SCG_IRQ_FAULT 0
`define SCG_IRQ_SLEEP 1
`define SCG_BIT_CMP_A 24
`define SCG_BIT_CMP_B 25
`define SCG_BIT_CMP_C 26
`define SCG_BIT_TMR_A 16
`define SCG_BIT_TMR_B 17
`define SCG_BIT_TMR_C 18
`define SCG_BIT_TWI 12
`define SCG_BIT_SSI 4
`define SCG_BIT_ASY_B 1
`define SCG_BIT_ASY_A 0
`endif

// ==== hw/scg_unit_gate.v ====
// Per-unit gate selection and bus fault check for one gated unit
`include "scg_map.vh"
module scg_unit_gate (
  input wire clock,
  input wire rst_b,
  input wire sleep_gate,
  input wire run_gate,
  input wire in_sleep,
  input wire auto_gating_select,
  input wire unit_access,
  output reg clk_en_q,
  output reg fault_q
);
  wire en_d;
  // Sleep value only rules when auto gating is chosen
  assign en_d = (in_sleep && auto_gating_select) ? sleep_gate : run_gate;
  // Enable registered so the gate never glitches; reset leaves unit off
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_en_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      clk_en_q <= en_d;
      fault_q <= unit_access && !en_d;
    end
  end
endmodule

// ==== hw/scg_top.v ====
// Sleep-mode unit clock gating register with bus fault and interrupt
`include "scg_map.vh"
module scg_top (
  input wire clock,
  input wire rst_b,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_q,
  input wire in_sleep,
  input wire [10:0] unit_access,
  output reg [10:0] unit_clk_en_q,
  output reg [10:0] bus_fault_q,
  output reg irq_q
);
  reg [31:0] sleep_gate_q;
  reg [31:0] run_gate_q;
  reg auto_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [3:0] fault_unit_q;
  reg sleep_prev_q;
  reg [31:0] rdata_d;
  reg [3:0] fu_d;
  integer k;
  wire [10:0] en_w;
  wire [10:0] flt_w;
  wire [1:0] ev_w;
  wire [1:0] stat_d;
  wire [10:0] sleep_bits_w;
  wire [10:0] run_bits_w;
  wire irq_d;
  wire wr_sleep_w;
  wire wr_run_w;
  wire wr_ctrl_w;
  wire wr_stat_w;
  wire wr_mask_w;
  wire [1:0] clr_w;
  wire comparator_c_clk_en;
  wire comparator_b_clk_en;
  wire comparator_a_clk_en;
  wire gp_counter_c_clk_en;
  wire gp_counter_b_clk_en;
  wire gp_counter_a_clk_en;
  wire twowire_port_a_clk_en;
  wire sync_serial_a_clk_en;
  wire async_serial_b_clk_en;
  wire async_serial_a_clk_en;

  // Sleep gate fields under their own names
  assign comparator_c_clk_en = sleep_gate_q[`SCG_BIT_CMP_C];
  assign comparator_b_clk_en = sleep_gate_q[`SCG_BIT_CMP_B];
  assign comparator_a_clk_en = sleep_gate_q[`SCG_BIT_CMP_A];
  assign gp_counter_c_clk_en = sleep_gate_q[`SCG_BIT_TMR_C];
  assign gp_counter_b_clk_en = sleep_gate_q[`SCG_BIT_TMR_B];
  assign gp_counter_a_clk_en = sleep_gate_q[`SCG_BIT_TMR_A];
  assign twowire_port_a_clk_en = sleep_gate_q[`SCG_BIT_TWI];
  assign sync_serial_a_clk_en = sleep_gate_q[`SCG_BIT_SSI];
  assign async_serial_b_clk_en = sleep_gate_q[`SCG_BIT_ASY_B];
  assign async_serial_a_clk_en = sleep_gate_q[`SCG_BIT_ASY_A];

  // Sleep fields in unit order; the spare top slot never gets a clock
  assign sleep_bits_w = {1'b0, comparator_c_clk_en, comparator_b_clk_en,
    comparator_a_clk_en, gp_counter_c_clk_en, gp_counter_b_clk_en, gp_counter_a_clk_en,
    twowire_port_a_clk_en, sync_serial_a_clk_en, async_serial_b_clk_en,
    async_serial_a_clk_en};

  // Run bits in the same order, wired fixed so no index mux sits in the path
  assign run_bits_w[0] = run_gate_q[`SCG_BIT_ASY_A];
  assign run_bits_w[1] = run_gate_q[`SCG_BIT_ASY_B];
  assign run_bits_w[2] = run_gate_q[`SCG_BIT_SSI];
  assign run_bits_w[3] = run_gate_q[`SCG_BIT_TWI];
  assign run_bits_w[4] = run_gate_q[`SCG_BIT_TMR_A];
  assign run_bits_w[5] = run_gate_q[`SCG_BIT_TMR_B];
  assign run_bits_w[6] = run_gate_q[`SCG_BIT_TMR_C];
  assign run_bits_w[7] = run_gate_q[`SCG_BIT_CMP_A];
  assign run_bits_w[8] = run_gate_q[`SCG_BIT_CMP_B];
  assign run_bits_w[9] = run_gate_q[`SCG_BIT_CMP_C];
  assign run_bits_w[10] = 1'b0;

  // One gate cell per unit
  genvar g;
  generate
    for (g = 0; g < `SCG_NUNITS; g = g + 1) begin : unit
      scg_unit_gate u_gate (
        .clock(clock),
        .rst_b(rst_b),
        .sleep_gate(sleep_bits_w[g]),
        .run_gate(run_bits_w[g]),
        .in_sleep(in_sleep),
        .auto_gating_select(auto_q),
        .unit_access(unit_access[g]),
        .clk_en_q(en_w[g]),
        .fault_q(flt_w[g])
      );
    end
  endgenerate
  // Events: a faulted access, and entry into sleep
  assign ev_w[`SCG_IRQ_FAULT] = |flt_w;
  assign ev_w[`SCG_IRQ_SLEEP] = in_sleep && !sleep_prev_q;
  // Write decodes, one per writable register
  assign wr_sleep_w = wr_stb && (addr == `SCG_OFF_SLEEP_GATE);
  assign wr_run_w = wr_stb && (addr == `SCG_OFF_RUN_GATE);
  assign wr_ctrl_w = wr_stb && (addr == `SCG_OFF_CTRL);
  assign wr_stat_w = wr_stb && (addr == `SCG_OFF_IRQ_STAT);
  assign wr_mask_w = wr_stb && (addr == `SCG_OFF_IRQ_MASK);
  // Write-one-to-clear pattern for the status bits
  assign clr_w = wr_stat_w ? wdata[`SCG_IRQ_W-1:0] : 2'b00;
  // Set wins over write-one-to-clear so no event is lost
  assign stat_d = ev_w | (stat_q & ~clr_w);
  // Lowest faulting unit index is latched for software
  always @* begin
    fu_d = fault_unit_q;
    for (k = `SCG_NUNITS - 1; k >= 0; k = k - 1) begin
      if (flt_w[k]) begin
        fu_d = k[3:0];
      end
    end
  end

  // Sleep gate; reserved bits are masked off so they always read zero
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_gate_q <= `SCG_GATE_RESET;
    end else if (wr_sleep_w) begin
      sleep_gate_q <= wdata & `SCG_RW_MASK;
    end
  end

  // Run gate; same layout and mask as the sleep gate
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_gate_q <= `SCG_GATE_RESET;
    end else if (wr_run_w) begin
      run_gate_q <= wdata & `SCG_RW_MASK;
    end
  end

  // Auto gating select, the one live bit of the control word
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      auto_q <= 1'b0;
    end else if (wr_ctrl_w) begin
      auto_q <= wdata[`SCG_CTRL_AUTO_BIT];
    end
  end

  // Interrupt mask
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= 2'b00;
    end else if (wr_mask_w) begin
      mask_q <= wdata[`SCG_IRQ_W-1:0];
    end
  end

  // Sticky status, updated every cycle from the set-wins equation
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= 2'b00;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Faulting unit index, held until a later fault replaces it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault_unit_q <= 4'h0;
    end else begin
      fault_unit_q <= fu_d;
    end
  end

  // Sleep level of the last cycle; resets to the idle level so no false entry
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= in_sleep;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (addr)
      `SCG_OFF_SLEEP_GATE: rdata_d = sleep_gate_q;
      `SCG_OFF_RUN_GATE: rdata_d = run_gate_q;
      `SCG_OFF_CTRL: rdata_d[`SCG_CTRL_AUTO_BIT] = auto_q;
      `SCG_OFF_IRQ_STAT: rdata_d[1:0] = stat_q;
      `SCG_OFF_IRQ_MASK: rdata_d[1:0] = mask_q;
      `SCG_OFF_FAULT_UNIT: rdata_d[3:0] = fault_unit_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Interrupt level from the status as it will stand next cycle
  assign irq_d = |(stat_d & mask_q);

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_stb ? rdata_d : 32'h0000_0000;
    end
  end

  // Unit enables; a second flop keeps the pins free of cell logic
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      unit_clk_en_q <= 11'h000;
    end else begin
      unit_clk_en_q <= en_w;
    end
  end

  // Bus faults, one cycle for every faulted access cycle
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_fault_q <= 11'h000;
    end else begin
      bus_fault_q <= flt_w;
    end
  end

  // Level interrupt output
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
endmodule

// ==== verification/scg_sva.sv ====
// Port checker for the sleep clock gating block
module scg_sva (
  input logic clock,
  input logic rst_b,
  input logic [11:0] addr,
  input logic rd_stb,
  input logic [31:0] rdata_q,
  input logic [10:0] unit_access,
  input logic [10:0] unit_clk_en_q,
  input logic [10:0] bus_fault_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_rsvd_read_zero: assert property (rd_stb && addr == 12'h114 |=>
    (rdata_q & 32'hF8F8_EFEC) == 0) else $error("reserved bit set");
  a_fault_when_off: assert property (unit_access[3] ##2 !unit_clk_en_q[3]
    |-> bus_fault_q[3]) else $error("fault missing");
  a_fault_has_cause: assert property (bus_fault_q[3] |->
    $past(unit_access[3], 2)) else $error("fault without access");
  a_spare_off: assert property (!unit_clk_en_q[10]) else $error("spare on");
  a_reset_all_off: assert property ($rose(rst_b) |-> unit_clk_en_q == 0)
    else $error("unit on at reset");
  a_fault_clk_off: assert property ((bus_fault_q & unit_clk_en_q) == 11'h000)
    else $error("fault on clocked unit");
  a_rdata_idle_zero: assert property (!rd_stb |=> rdata_q == 32'h0000_0000)
    else $error("read data without strobe");
endmodule
bind scg_top scg_sva u_sva (.clock(clock), .rst_b(rst_b), .addr(addr), .rd_stb(rd_stb),
  .rdata_q(rdata_q), .unit_access(unit_access), .unit_clk_en_q(unit_clk_en_q),
  .bus_fault_q(bus_fault_q));

// ==== verification/sleep_clock_gating_reg_tb.sv ====
// Bench for the sleep clock gating register
module sleep_clock_gating_reg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, in_sleep = 0, irq_q;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata_q, gate, acc, seed = 70;
  logic [10:0] unit_access = 0, unit_clk_en_q, bus_fault_q;
  int num_errors = 0, compares = 0;
`define CHK(g, e) chk(32'(g), 32'(e));
  scg_top DUT (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_q(rdata_q), .in_sleep(in_sleep), .unit_access(unit_access),
    .unit_clk_en_q(unit_clk_en_q), .bus_fault_q(bus_fault_q), .irq_q(irq_q));
  // Clock at 25 MHz
  always #20 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Model of the unit enables that a gate word asks for
  function automatic logic [10:0] ens(logic [31:0] g);
    return {1'b0, g[26:24], g[18:16], g[12], g[4], g[1:0]};
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    wr_stb <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(posedge clock);
    rd_stb <= 1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 0;
    #1 `CHK(rdata_q, e)
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1;
    rd(12'h114, 0);
    wr(12'h060, 32'h0800_0000);
    in_sleep <= 1;
    for (int i = 0; i < 8; i++) begin
      gate = rnd();
      wr(12'h114, gate);
      rd(12'h114, gate & 32'h0707_1013);
      `CHK(unit_clk_en_q, ens(gate))
    end
    // Read-modify-write that hands the reserved bits back as read
    rd(12'h114, gate & 32'h0707_1013);
    gate = rdata_q ^ 32'h0000_1000;
    wr(12'h114, gate);
    rd(12'h114, gate);
    `CHK(unit_clk_en_q, ens(gate))
    rd(12'h3FC, 0);
    rd(12'h060, 32'h0800_0000);
    @(posedge clock);
    in_sleep <= 0;
    repeat (3) @(posedge clock);
    #1 `CHK(unit_clk_en_q, 0)
    wr(12'h204, 1);
    rd(12'h204, 1);
    @(posedge clock);
    unit_access <= 11'h008;
    @(posedge clock);
    unit_access <= 0;
    @(posedge clock);
    #1 `CHK(bus_fault_q, 11'h008)
    repeat (2) @(posedge clock);
    #1 `CHK(irq_q, 1)
    rd(12'h200, 3);
    rd(12'h208, 3);
    wr(12'h200, 1);
    repeat (3) @(posedge clock);
    #1 `CHK(irq_q, 0)
    rd(12'h200, 2);
    // Sleep entry interrupt, then its clear
    wr(12'h204, 2);
    repeat (2) @(posedge clock);
    #1 `CHK(irq_q, 1)
    wr(12'h200, 2);
    repeat (2) @(posedge clock);
    #1 `CHK(irq_q, 0)
    // Run gate governs while awake
    gate = rnd();
    wr(12'h104, gate);
    rd(12'h104, gate & 32'h0707_1013);
    `CHK(unit_clk_en_q, ens(gate))
    // Random accesses fault exactly on the unclocked units
    @(posedge clock);
    acc = rnd();
    unit_access <= acc[10:0];
    @(posedge clock);
    unit_access <= 0;
    @(posedge clock);
    #1 `CHK(bus_fault_q, acc[10:0] & ~ens(gate))
    // Without auto select the run gate still rules in sleep
    wr(12'h060, 0);
    rd(12'h060, 0);
    @(posedge clock);
    in_sleep <= 1;
    repeat (3) @(posedge clock);
    #1 `CHK(unit_clk_en_q, ens(gate))
    `CHK(irq_q, 1)
    summarize();
  end
  // Watchdog well beyond the hundred or so cycles the run needs
  initial begin
    #40us;
    num_errors++;
    summarize();
  end
endmodule
